// *** core/stx_exec.sv ***
// Functional notes
// RULE1 - null-byte skip: byte zero squashes prefetch, dummy cycle, 2 cycles; else 1.
// RULE2 - load-then-skip copies byte to working register; zero byte squashes prefetch.
// RULE3 - bit-test skip: selected bit zero squashes prefetch with dummy cycle; else 1 cycle.
// RULE4 - current-page table read: low byte to memory, high byte to high latch.
// RULE5 - final-page table read: low byte to memory, high byte to high latch.
// RULE6 - register-memory xor into working register, only null flag updated.
// RULE7 - xor to memory writes result back to the byte, updates null flag.
// RULE8 - immediate xor into working register, null flag set from result.
// RULE9 - nibble exchange writes swapped byte to working register, memory untouched.
// RULE10 - skips, table reads, nibble exchange keep flags; xor touches only null flag.
`timescale 1ns/1ps
module stx_exec
  import stx_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   op_valid,     // one instruction per cycle
  input  wire stx_op_t                op_code,
  input  wire logic [STX_DATA_W-1:0]  mem_rdata,    // addressed data byte
  input  wire logic [2:0]             bit_sel,
  input  wire logic [STX_DATA_W-1:0]  imm_data,
  input  wire logic [STX_PADDR_W-1:0] pc_now,       // address of current instruction
  input  wire logic [STX_DATA_W-1:0]  table_pointer,
  input  wire logic [STX_PROG_W-1:0]  prog_rdata,   // program word, combinational reply
  output logic [STX_PADDR_W-1:0]      prog_addr,
  output logic                        busy,         // stalls decode in dummy cycle
  output logic                        squash,       // discard prefetched instruction
  output logic                        mem_we,
  output logic [STX_DATA_W-1:0]       mem_wdata,
  output logic [STX_DATA_W-1:0]       working_register,
  output logic [STX_HIGH_W-1:0]       table_high_latch,
  output logic                        zero_flag
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic is_null(input logic [STX_DATA_W-1:0] v);
    is_null = (v == '0);
  endfunction : is_null

  logic                  dummy;
  wire logic             go         = op_valid && !dummy;
  wire logic             byte_null  = is_null(mem_rdata);
  wire logic             bit_clear  = !mem_rdata[bit_sel];
  wire logic             is_tab     = (op_code == STX_OP_TAB_CUR) || (op_code == STX_OP_TAB_FIN);
  wire logic [STX_DATA_W-1:0] xor_mem = working_register ^ mem_rdata;
  wire logic [STX_DATA_W-1:0] xor_imm = working_register ^ imm_data;
  wire logic [STX_DATA_W-1:0] nib_x   = {mem_rdata[3:0], mem_rdata[7:4]};
  // page bits come from the current pc or are forced to the final page
  wire logic [STX_PAGE_W-1:0] page_sel = (op_code == STX_OP_TAB_FIN) ? STX_FINAL_PAGE :
                                          pc_now[STX_PADDR_W-1 -: STX_PAGE_W]; // RULE4 RULE5

  // skip decision: skips of a zero byte or a clear bit
  logic do_skip;
  always_comb begin
    do_skip = 1'b0;
    if (go) begin
      unique case (op_code)
        STX_OP_SKIP_NULL: do_skip = byte_null;  // RULE1
        STX_OP_LOAD_SKIP: do_skip = byte_null;  // RULE2
        STX_OP_SKIP_BIT:  do_skip = bit_clear;  // RULE3
        default:          do_skip = 1'b0;
      endcase
    end
  end

  // squash is combinational so fetch can drop the prefetch in the same cycle
  assign squash    = do_skip;  // RULE1
  assign busy      = dummy;
  assign prog_addr = {page_sel, table_pointer};

  // next-state of working register, flag and memory write
  logic [STX_DATA_W-1:0] next_acc;
  logic                  next_zf;
  logic                  next_we;
  logic [STX_DATA_W-1:0] next_wdata;
  always_comb begin
    next_acc   = working_register;
    next_zf    = zero_flag;  // RULE10
    next_we    = 1'b0;
    next_wdata = mem_wdata;
    if (go) begin
      unique case (op_code)
        STX_OP_LOAD_SKIP: next_acc = mem_rdata;  // RULE2
        STX_OP_XOR_ACC: begin
          next_acc = xor_mem;           // RULE6
          next_zf  = is_null(xor_mem);  // RULE6
        end
        STX_OP_XOR_MEM: begin
          next_we    = 1'b1;              // RULE7
          next_wdata = xor_mem;
          next_zf    = is_null(xor_mem);  // RULE7
        end
        STX_OP_XOR_IMM: begin
          next_acc = xor_imm;           // RULE8
          next_zf  = is_null(xor_imm);  // RULE8
        end
        STX_OP_NIB_EXCH: next_acc = nib_x;  // RULE9
        STX_OP_TAB_CUR, STX_OP_TAB_FIN: begin
          next_we    = 1'b1;                         // RULE4 RULE5
          next_wdata = prog_rdata[STX_DATA_W-1:0];
        end
        default: next_acc = working_register;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // the dummy cycle is one extra cycle, giving 2 in total for a skip
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dummy <= 1'b0;
    end else begin
      dummy <= do_skip;  // RULE1 RULE3
    end
  end

  // architectural registers; memory write is registered, one cycle late
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      working_register <= STX_RST_ACC;
      zero_flag        <= STX_RST_ZFLAG;
      mem_we           <= 1'b0;
      mem_wdata        <= '0;
      table_high_latch <= STX_RST_THIGH;
    end else begin
      working_register <= next_acc;
      zero_flag        <= next_zf;
      mem_we           <= next_we;
      mem_wdata        <= next_wdata;
      if (go && is_tab) begin
        table_high_latch <= prog_rdata[STX_PROG_W-1:STX_DATA_W];  // RULE4 RULE5
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_skip_taken;
    go && ((op_code == STX_OP_SKIP_NULL) || (op_code == STX_OP_LOAD_SKIP)) && byte_null;
  endsequence
  sequence s_dummy_then_free;
    busy ##1 !busy;
  endsequence

  property p_null_skip;
    @(posedge ref_clk) disable iff (!rst_b) s_skip_taken |-> squash ##1 s_dummy_then_free;
  endproperty
  a_null_skip: assert property (p_null_skip) else $error("null skip timing wrong"); // RULE1

  property p_no_skip_nonzero;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_SKIP_NULL && !byte_null) |-> !squash ##1 !busy;
  endproperty
  a_no_skip_nonzero: assert property (p_no_skip_nonzero) else $error("false skip"); // RULE1

  property p_load_skip;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_LOAD_SKIP) |=> working_register == $past(mem_rdata);
  endproperty
  a_load_skip: assert property (p_load_skip) else $error("load skip copy wrong"); // RULE2

  property p_bit_skip;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_SKIP_BIT) |-> (squash == !mem_rdata[bit_sel]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong"); // RULE3

  property p_table;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && is_tab) |=> mem_we && mem_wdata == $past(prog_rdata[7:0])
        && table_high_latch == $past(prog_rdata[13:8]);
  endproperty
  a_table: assert property (p_table) else $error("table read wrong"); // RULE4

  property p_final_page;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_TAB_FIN) |-> prog_addr[9:8] == STX_FINAL_PAGE;
  endproperty
  a_final_page: assert property (p_final_page) else $error("final page wrong"); // RULE5

  property p_xor_acc;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_XOR_ACC) |=>
        working_register == ($past(working_register) ^ $past(mem_rdata))
        && zero_flag == (working_register == 8'h00) && !mem_we;
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor acc wrong"); // RULE6

  property p_xor_mem;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_XOR_MEM) |=> mem_we && $stable(working_register)
        && mem_wdata == ($past(working_register) ^ $past(mem_rdata))
        && zero_flag == (mem_wdata == 8'h00);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor mem wrong"); // RULE7

  property p_xor_imm;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_XOR_IMM) |=>
        working_register == ($past(working_register) ^ $past(imm_data))
        && zero_flag == (working_register == 8'h00);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor imm wrong"); // RULE8

  property p_nib;
    @(posedge ref_clk) disable iff (!rst_b)
      (go && op_code == STX_OP_NIB_EXCH) |=>
        working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && !mem_we;
  endproperty
  a_nib: assert property (p_nib) else $error("nibble exchange wrong"); // RULE9

  property p_flags_kept;
    @(posedge ref_clk) disable iff (!rst_b)
      (!go || !(op_code inside {STX_OP_XOR_ACC, STX_OP_XOR_MEM, STX_OP_XOR_IMM}))
        |=> $stable(zero_flag);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flag changed"); // RULE10

endmodule : stx_exec

// *** include/stx_pkg.sv ***
package stx_pkg;
  // ----------------------------------------------------------------
  // operation codes presented by the decode stage
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    STX_OP_NONE      = 4'h0,
    STX_OP_SKIP_NULL = 4'h1,  // skip_if_null_byte
    STX_OP_LOAD_SKIP = 4'h2,  // load_then_skip_if_null
    STX_OP_SKIP_BIT  = 4'h3,  // skip if selected bit is zero
    STX_OP_TAB_CUR   = 4'h4,  // table_read_current_page
    STX_OP_TAB_FIN   = 4'h5,  // table_read_final_page
    STX_OP_XOR_ACC   = 4'h6,  // working_register ^= byte
    STX_OP_XOR_MEM   = 4'h7,  // exclusive_or_to_memory
    STX_OP_XOR_IMM   = 4'h8,  // working_register ^= immediate
    STX_OP_NIB_EXCH  = 4'h9   // nibble_exchange_to_working
  } stx_op_t;

  // ----------------------------------------------------------------
  // widths and layout
  // ----------------------------------------------------------------
  localparam int  STX_DATA_W    = 8;
  localparam int  STX_PROG_W    = 14;
  localparam int  STX_PADDR_W   = 10;
  localparam int  STX_PAGE_W    = 2;   // upper program address bits form the page
  localparam int  STX_HIGH_W    = STX_PROG_W - STX_DATA_W;
  localparam logic [STX_PAGE_W-1:0] STX_FINAL_PAGE = 2'h3;
  localparam logic [STX_DATA_W-1:0] STX_RST_ACC    = 8'h00;
  localparam logic [STX_HIGH_W-1:0] STX_RST_THIGH  = 6'h00;
  localparam logic                  STX_RST_ZFLAG  = 1'b0;
  // cycles spent by a non-skipping and a skipping instruction
  localparam int  STX_CYC_PLAIN = 1;
  localparam int  STX_CYC_SKIP  = 2;
endpackage : stx_pkg

// *** sim/test_skip_table_xor_exec.sv ***
`timescale 1ns/1ps
module test_skip_table_xor_exec
  import stx_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, design and reference state
  // ----------------------------------------------------------------
  logic                   ref_clk, rst_b, op_valid;
  stx_op_t                op_code;
  logic [STX_DATA_W-1:0]  mem_rdata, imm_data, table_pointer, mem_wdata, working_register;
  logic [2:0]             bit_sel;
  logic [STX_PADDR_W-1:0] pc_now, prog_addr;
  logic [STX_PROG_W-1:0]  prog_rdata;
  logic [STX_HIGH_W-1:0]  table_high_latch;
  logic                   busy, squash, mem_we, zero_flag;
  int                     err_total = 0, samples_checked = 0;
  int                     acc = 0, zf = 0, thigh = 0;  // reference model state

  stx_exec stx_exec_i (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .bit_sel(bit_sel), .imm_data(imm_data),
    .pc_now(pc_now), .table_pointer(table_pointer), .prog_rdata(prog_rdata),
    .prog_addr(prog_addr), .busy(busy), .squash(squash), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .working_register(working_register),
    .table_high_latch(table_high_latch), .zero_flag(zero_flag));

  // 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // a hang is cut short well past the expected run of about 700 cycles
  initial begin
    #60000;
    err_total++;
    give_verdict();
  end

  task give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task chk_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", name, exp, got);
    end
  endtask : chk_bit

  task chk_vec(input string name, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk_vec

  // registered outputs against the model, one edge after the operation
  task check_state(input int we, input int wd, input int bz);
    chk_bit("busy", bz[0], busy);
    chk_bit("mem_we", we[0], mem_we);
    if (we != 0) chk_vec("mem_wdata", 14'(wd), 14'(mem_wdata));
    chk_vec("working_register", 14'(acc), 14'(working_register));
    chk_vec("table_high_latch", 14'(thigh), 14'(table_high_latch));
    chk_bit("zero_flag", zf[0], zero_flag);
  endtask : check_state

  // ----------------------------------------------------------------
  // one instruction, with a refused one thrown in during a dummy cycle
  // ----------------------------------------------------------------
  task run_op(input stx_op_t op);
    int m, b, im, tp, pc, pw, skip, we, wd, pa, cyc;
    m = ($urandom % 4 == 0) ? 0 : $urandom % 256;  // zero bytes often, to reach skips
    b = $urandom % 8;
    im = $urandom % 256;
    tp = $urandom % 256;
    pc = $urandom % 1024;
    pw = $urandom % 16384;
    skip = 0;
    we = 0;
    wd = 0;
    pa = -1;
    case (op)
      STX_OP_SKIP_NULL: skip = (m == 0);
      STX_OP_LOAD_SKIP: begin
        acc = m;
        skip = (m == 0);
      end
      STX_OP_SKIP_BIT: skip = ((m >> b) % 2 == 0);
      STX_OP_TAB_CUR, STX_OP_TAB_FIN: begin
        pa = ((op == STX_OP_TAB_FIN) ? 3 : pc / 256) * 256 + tp;
        we = 1;
        wd = pw % 256;
        thigh = pw / 256;
      end
      STX_OP_XOR_ACC: begin
        acc = acc ^ m;
        zf = (acc == 0);
      end
      STX_OP_XOR_MEM: begin
        we = 1;
        wd = acc ^ m;
        zf = (wd == 0);
      end
      STX_OP_XOR_IMM: begin
        acc = acc ^ im;
        zf = (acc == 0);
      end
      STX_OP_NIB_EXCH: acc = (m % 16) * 16 + m / 16;
      default: ;
    endcase
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    mem_rdata <= 8'(m);
    bit_sel <= 3'(b);
    imm_data <= 8'(im);
    table_pointer <= 8'(tp);
    pc_now <= 10'(pc);
    prog_rdata <= 14'(pw);
    #1;
    chk_bit("squash", skip[0], squash);
    if (pa >= 0) chk_vec("prog_addr", 14'(pa), 14'(prog_addr));
    @(posedge ref_clk);
    // an xor offered in the dummy cycle would move the working register if taken
    op_valid <= skip[0];
    op_code <= STX_OP_XOR_IMM;
    imm_data <= 8'h5A;
    #1;
    check_state(we, wd, skip);
    cyc = 1;
    if (busy === 1'b1) cyc++;
    if (skip != 0) begin
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
      check_state(0, 0, 0);
      if (busy === 1'b1) cyc++;
    end
    // cycles spent: the op cycle plus every cycle in which busy held decode off
    chk_vec("cycles", 14'((skip != 0) ? STX_CYC_SKIP : STX_CYC_PLAIN), 14'(cyc));
  endtask : run_op

  initial begin
    void'($urandom(32'h89249519));
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = STX_OP_NONE;
    mem_rdata = 8'h00;
    imm_data = 8'h00;
    table_pointer = 8'h00;
    bit_sel = 3'h0;
    pc_now = 10'h000;
    prog_rdata = 14'h0000;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check_state(0, 0, 0);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 10; i++) run_op(stx_op_t'(i));
    end
    // reset in mid-run wins over an op offered in the same cycle
    @(posedge ref_clk);
    rst_b <= 1'b0;
    op_valid <= 1'b1;
    op_code <= STX_OP_XOR_IMM;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    op_valid <= 1'b0;
    acc = 0;
    zf = 0;
    thigh = 0;
    #1;
    check_state(0, 0, 0);
    repeat (300) run_op(stx_op_t'($urandom % 10));
    give_verdict();
  end
endmodule : test_skip_table_xor_exec
